// [shared/gpm_pkg.sv]
// Package: register map, gamut preset values and luminance and sample figures of the gamut preset decoder
//////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Gamut map selector permits only codes 0-1, 4-5 and 64-127.
// - Code 0 picks implementation method, code 1 picks explicitly transmitted parameters.
// - Codes 2-3, 6-63, 128-255 reserved; codes 64-127 carry unspecified meaning.
// - Code 4 loads first preset: cinema gamut in wide primaries to standard gamut.
// - Code 5 loads second preset: full wide gamut down to standard gamut.
// - First preset: saturation 1, ratios 7/8 and 29/64, lightness 2, crop 0, hue 3.
// - First preset keep ratios 7/8 except fifth 6/8; align present, values 4,1,2,4,5,1.
// - Second preset: lightness 2, crop 0, hue 2, align 4,1,2,4,5,1, single keep ratio.
// - Carriage selector 0 routes to parameter path, 1 routes to table path.
// - Each decoded picture is combined with its own metadata to form the output.
// - Adaptation off gives SDR output; adaptation on gives display-adapted HDR output.
// - Accepted target peak spans from 100 cd/m2 to above the mastering peak.
// - SDR output uses peak 100 cd/m2 and leaves metadata values unmodified.
// - Input is full range with 10-bit samples, largest sample count 1024.
package gpm_pkg;

    // APB register byte offsets
    localparam logic [7:0] GPM_OFF_CTRL = 8'h00;
    localparam logic [7:0] GPM_OFF_PEAK = 8'h04;
    localparam logic [7:0] GPM_OFF_STATUS = 8'h08;
    localparam logic [7:0] GPM_OFF_MASK = 8'h0c;
    localparam logic [7:0] GPM_OFF_ACTIVE = 8'h10;

    // Field positions
    localparam int GPM_CTRL_ADAPT_BIT = 0;
    localparam int GPM_ST_BAD_SEL = 0;
    localparam int GPM_ST_PIC = 1;
    localparam int GPM_ST_CLAMP = 2;
    localparam int GPM_ST_WIDTH = 3;
    localparam int GPM_PEAK_WIDTH = 14;

    // Reset values
    localparam logic GPM_CTRL_RST = 1'b0;
    localparam logic [13:0] GPM_PEAK_RST = 14'h0064;
    localparam logic [2:0] GPM_MASK_RST = 3'h0;

    // Luminance and sample figures
    localparam logic [13:0] GPM_SDR_PEAK = 14'h0064;
    localparam int GPM_MAX_SAMPLE_VAL = 1024;

    // Gamut map selector codes
    localparam logic [7:0] GPM_CODE_IMPL = 8'h00;
    localparam logic [7:0] GPM_CODE_EXPLICIT = 8'h01;
    localparam logic [7:0] GPM_CODE_PRESET_A = 8'h04;
    localparam logic [7:0] GPM_CODE_PRESET_B = 8'h05;
    localparam logic [7:0] GPM_CODE_UNSPEC_LO = 8'h40;
    localparam logic [7:0] GPM_CODE_UNSPEC_HI = 8'h7f;

    // Ratios are in 64ths
    localparam logic [6:0] GPM_RATIO_7_8 = 7'h38;
    localparam logic [6:0] GPM_RATIO_6_8 = 7'h30;
    localparam logic [6:0] GPM_RATIO_29_64 = 7'h1d;
    localparam logic [3:0] GPM_SAT_MAP_PRESET = 4'h1;
    localparam logic [3:0] GPM_LIGHT_MAP_PRESET = 4'h2;
    localparam logic [3:0] GPM_CROP_PRESET = 4'h0;
    localparam logic [3:0] GPM_HUE_ADJ_A = 4'h3;
    localparam logic [3:0] GPM_HUE_ADJ_B = 4'h2;
    // Sector 0 in the low bits
    localparam logic [41:0] GPM_KEEP_A = {7'h38, 7'h30, 7'h38, 7'h38, 7'h38, 7'h38};
    localparam logic [17:0] GPM_ALIGN_SET = {3'h1, 3'h5, 3'h4, 3'h2, 3'h1, 3'h4};
    localparam logic [6:0] GPM_KEEP_OVERALL_B = 7'h38;

    typedef enum logic [2:0] {
        GM_IMPL,
        GM_EXPLICIT,
        GM_PRESET_A,
        GM_PRESET_B,
        GM_UNSPEC
    } gpm_gm_type;

endpackage : gpm_pkg

// [src/gpm_preset_rom.sv]
// Module: expands the active gamut method into the registered preset parameter set
`timescale 1ns/1ps
`default_nettype none
module gpm_preset_rom #(
    parameter logic [6:0] KEEP_OVERALL = gpm_pkg::GPM_KEEP_OVERALL_B
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire gpm_pkg::gpm_gm_type mode,
    output logic preset_valid,
    output logic [3:0] sat_map_sel,
    output logic [6:0] sat_ratio_1seg,
    output logic [6:0] sat_ratio_2seg_wide,
    output logic [6:0] sat_ratio_2seg_std,
    output logic [3:0] light_map_sel,
    output logic [3:0] crop_sel,
    output logic [3:0] hue_adj_sel,
    output logic [41:0] hue_keep_sectors,
    output logic [6:0] hue_keep_overall,
    output logic hue_align_present,
    output logic [17:0] hue_align_sectors,
    output logic chroma_adjust_present
);
    import gpm_pkg::*;

    wire is_a = (mode == GM_PRESET_A);
    wire is_b = (mode == GM_PRESET_B);
    wire is_preset = is_a | is_b;
    logic [41:0] keep_next;

    // Per-sector keep ratios only exist in the first preset
    genvar s;
    generate
        for (s = 0; s < 6; s++) begin : g_sector
            assign keep_next[7*s +: 7] = is_a ? GPM_KEEP_A[7*s +: 7] : 7'h00;
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            preset_valid <= 1'b0;
            sat_map_sel <= 4'h0;
            sat_ratio_1seg <= 7'h00;
            sat_ratio_2seg_wide <= 7'h00;
            sat_ratio_2seg_std <= 7'h00;
            light_map_sel <= 4'h0;
            crop_sel <= 4'h0;
            hue_adj_sel <= 4'h0;
            hue_keep_sectors <= 42'h0;
            hue_keep_overall <= 7'h00;
            hue_align_present <= 1'b0;
            hue_align_sectors <= 18'h0;
            chroma_adjust_present <= 1'b0;
        end else if (load) begin
            preset_valid <= is_preset;
            sat_map_sel <= is_preset ? GPM_SAT_MAP_PRESET : 4'h0;
            sat_ratio_1seg <= is_preset ? GPM_RATIO_7_8 : 7'h00;
            sat_ratio_2seg_wide <= is_preset ? GPM_RATIO_29_64 : 7'h00;
            sat_ratio_2seg_std <= is_preset ? GPM_RATIO_29_64 : 7'h00;
            light_map_sel <= is_preset ? GPM_LIGHT_MAP_PRESET : 4'h0;
            crop_sel <= GPM_CROP_PRESET;
            hue_adj_sel <= is_a ? GPM_HUE_ADJ_A : (is_b ? GPM_HUE_ADJ_B : 4'h0);
            hue_keep_sectors <= keep_next;
            hue_keep_overall <= is_b ? KEEP_OVERALL : 7'h00;
            hue_align_present <= is_preset;
            hue_align_sectors <= is_preset ? GPM_ALIGN_SET : 18'h0;
            chroma_adjust_present <= 1'b0;
        end
    end
endmodule : gpm_preset_rom
`default_nettype wire

// [src/gpm_decoder.sv]
// Module: gamut preset metadata decoder with APB registers, picture tagging and interrupt
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gpm_decoder #(
    parameter int SAMPLE_BITS = $clog2(gpm_pkg::GPM_MAX_SAMPLE_VAL),
    parameter logic [6:0] KEEP_OVERALL = gpm_pkg::GPM_KEEP_OVERALL_B
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MD_VALID,
    input wire logic [7:0] MD_GAMUT_SEL,
    input wire logic MD_CARRIAGE,
    input wire logic VID_VALID,
    input wire logic VID_SOF,
    input wire logic [3*SAMPLE_BITS-1:0] VID_SAMPLE,
    output logic OUT_VALID,
    output logic OUT_SOF,
    output logic [3*SAMPLE_BITS-1:0] OUT_SAMPLE,
    output logic OUT_HDR,
    output logic [13:0] OUT_PEAK_LUM,
    output logic RECOMPUTE_EN,
    output logic PATH_PARAM_EN,
    output logic PATH_TABLE_EN,
    output gpm_pkg::gpm_gm_type GM_METHOD,
    output logic PRESET_VALID,
    output logic [3:0] SAT_MAP_SEL,
    output logic [6:0] SAT_RATIO_1SEG,
    output logic [6:0] SAT_RATIO_2SEG_WIDE,
    output logic [6:0] SAT_RATIO_2SEG_STD,
    output logic [3:0] LIGHT_MAP_SEL,
    output logic [3:0] CROP_SEL,
    output logic [3:0] HUE_ADJ_SEL,
    output logic [41:0] HUE_KEEP_SECTORS,
    output logic [6:0] HUE_KEEP_OVERALL,
    output logic HUE_ALIGN_PRESENT,
    output logic [17:0] HUE_ALIGN_SECTORS,
    output logic CHROMA_ADJUST_PRESENT,
    output logic IRQ
);
    import gpm_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // APB decode
    logic ctrl_adapt_reg;
    logic [13:0] peak_reg;
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic [2:0] mask_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdata_mux;

    wire apb_setup = PSEL & ~PENABLE;
    wire apb_access = PSEL & PENABLE;
    wire apb_wr = apb_access & PWRITE;
    wire hit_ctrl = (PADDR == GPM_OFF_CTRL);
    wire hit_peak = (PADDR == GPM_OFF_PEAK);
    wire hit_status = (PADDR == GPM_OFF_STATUS);
    wire hit_mask = (PADDR == GPM_OFF_MASK);
    wire hit_active = (PADDR == GPM_OFF_ACTIVE);
    wire addr_ok = hit_ctrl | hit_peak | hit_status | hit_mask | hit_active;
    wire wr_ctrl = apb_wr & hit_ctrl;
    wire wr_peak = apb_wr & hit_peak;
    wire wr_status = apb_wr & hit_status;
    wire wr_mask = apb_wr & hit_mask;

    // Zero-wait slave: read data is captured in the setup phase
    assign PREADY = 1'b1;
    assign PSLVERR = apb_access & ~addr_ok;
    assign PRDATA = prdata_reg;

    //////////////////////////////////////////////////////////////////////////
    // Target peak luminance, lower bound clamp
    wire [13:0] peak_wdata = PWDATA[13:0];
    wire peak_low = peak_wdata < GPM_SDR_PEAK;
    wire [13:0] peak_accept = peak_low ? GPM_SDR_PEAK : peak_wdata;

    //////////////////////////////////////////////////////////////////////////
    // Selector classification
    wire in_unspec = (MD_GAMUT_SEL >= GPM_CODE_UNSPEC_LO) && (MD_GAMUT_SEL <= GPM_CODE_UNSPEC_HI);
    wire is_impl = (MD_GAMUT_SEL == GPM_CODE_IMPL);
    wire is_expl = (MD_GAMUT_SEL == GPM_CODE_EXPLICIT);
    wire is_pa = (MD_GAMUT_SEL == GPM_CODE_PRESET_A);
    wire is_pb = (MD_GAMUT_SEL == GPM_CODE_PRESET_B);
    wire sel_ok = is_impl | is_expl | is_pa | is_pb | in_unspec;
    wire bad_sel = MD_VALID & ~sel_ok;
    gpm_gm_type md_mode;

    // Reserved codes fall back to the implementation method
    assign md_mode = is_expl ? GM_EXPLICIT :
                     is_pa ? GM_PRESET_A :
                     is_pb ? GM_PRESET_B :
                     in_unspec ? GM_UNSPEC : GM_IMPL;

    //////////////////////////////////////////////////////////////////////////
    // Pending metadata for the next picture
    gpm_gm_type pend_mode_reg;
    logic pend_carr_reg;
    gpm_gm_type act_mode_reg;
    logic act_carr_reg;
    logic act_hdr_reg;
    logic [13:0] act_peak_reg;

    wire pic_start = VID_VALID & VID_SOF;
    // Metadata arriving with the first sample belongs to that picture
    gpm_gm_type new_mode;
    assign new_mode = MD_VALID ? md_mode : pend_mode_reg;
    wire new_carr = MD_VALID ? MD_CARRIAGE : pend_carr_reg;
    gpm_gm_type sel_mode;
    assign sel_mode = pic_start ? new_mode : act_mode_reg;
    wire sel_carr = pic_start ? new_carr : act_carr_reg;
    wire sel_hdr = pic_start ? ctrl_adapt_reg : act_hdr_reg;
    // SDR output always runs at the fixed SDR peak
    wire [13:0] sel_peak = pic_start ? (ctrl_adapt_reg ? peak_reg : GPM_SDR_PEAK)
                                     : act_peak_reg;

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status
    wire [2:0] st_set = {wr_peak & peak_low, pic_start, bad_sel};
    wire [2:0] st_clr = wr_status ? PWDATA[2:0] : 3'h0;
    assign status_next = (status_reg & ~st_clr) | st_set;
    assign IRQ = |(status_reg & mask_reg);

    assign rdata_mux = hit_ctrl ? {31'h0, ctrl_adapt_reg} :
                       hit_peak ? {18'h0, peak_reg} :
                       hit_status ? {29'h0, status_reg} :
                       hit_mask ? {29'h0, mask_reg} :
                       hit_active ? {2'h0, act_peak_reg, 10'h0, act_mode_reg,
                                     1'b0, act_hdr_reg, act_carr_reg} :
                       32'h0;

    //////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_adapt_reg <= GPM_CTRL_RST;
            peak_reg <= GPM_PEAK_RST;
            status_reg <= 3'h0;
            mask_reg <= GPM_MASK_RST;
            prdata_reg <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_adapt_reg <= PWDATA[GPM_CTRL_ADAPT_BIT];
            end
            if (wr_peak) begin
                peak_reg <= peak_accept;
            end
            if (wr_mask) begin
                mask_reg <= PWDATA[2:0];
            end
            status_reg <= status_next;
            if (apb_setup) begin
                prdata_reg <= rdata_mux;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_mode_reg <= GM_IMPL;
            pend_carr_reg <= 1'b0;
        end else if (MD_VALID) begin
            pend_mode_reg <= md_mode;
            pend_carr_reg <= MD_CARRIAGE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            act_mode_reg <= GM_IMPL;
            act_carr_reg <= 1'b0;
            act_hdr_reg <= 1'b0;
            act_peak_reg <= GPM_SDR_PEAK;
        end else begin
            act_mode_reg <= sel_mode;
            act_carr_reg <= sel_carr;
            act_hdr_reg <= sel_hdr;
            act_peak_reg <= sel_peak;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Picture path, one register stage tagged with its metadata
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            OUT_VALID <= 1'b0;
            OUT_SOF <= 1'b0;
            OUT_SAMPLE <= '0;
        end else begin
            OUT_VALID <= VID_VALID;
            OUT_SOF <= pic_start;
            OUT_SAMPLE <= VID_SAMPLE;
        end
    end

    assign OUT_HDR = act_hdr_reg;
    assign OUT_PEAK_LUM = act_peak_reg;
    assign RECOMPUTE_EN = act_hdr_reg;
    assign PATH_PARAM_EN = ~act_carr_reg;
    assign PATH_TABLE_EN = act_carr_reg;
    assign GM_METHOD = act_mode_reg;

    gpm_preset_rom #(
        .KEEP_OVERALL(KEEP_OVERALL)
    ) u_rom (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .load(pic_start),
        .mode(new_mode),
        .preset_valid(PRESET_VALID),
        .sat_map_sel(SAT_MAP_SEL),
        .sat_ratio_1seg(SAT_RATIO_1SEG),
        .sat_ratio_2seg_wide(SAT_RATIO_2SEG_WIDE),
        .sat_ratio_2seg_std(SAT_RATIO_2SEG_STD),
        .light_map_sel(LIGHT_MAP_SEL),
        .crop_sel(CROP_SEL),
        .hue_adj_sel(HUE_ADJ_SEL),
        .hue_keep_sectors(HUE_KEEP_SECTORS),
        .hue_keep_overall(HUE_KEEP_OVERALL),
        .hue_align_present(HUE_ALIGN_PRESENT),
        .hue_align_sectors(HUE_ALIGN_SECTORS),
        .chroma_adjust_present(CHROMA_ADJUST_PRESENT)
    );

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    a_bad_sel_flag: assert property (
        MD_VALID && !sel_ok |=> status_reg[GPM_ST_BAD_SEL])
        else $error("reserved selector did not raise the flag");

    a_reserved_fallback: assert property (
        pic_start && MD_VALID && (MD_GAMUT_SEL == 8'h02 || MD_GAMUT_SEL >= 8'h80)
        |=> GM_METHOD == GM_IMPL)
        else $error("reserved selector did not fall back");

    a_preset_a_load: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_PRESET_A
        |=> PRESET_VALID && HUE_ADJ_SEL == 4'h3 && SAT_RATIO_2SEG_STD == 7'h1d)
        else $error("first preset not loaded");

    a_preset_a_keep: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_PRESET_A
        |=> HUE_KEEP_SECTORS[34:28] == 7'h30 && HUE_KEEP_SECTORS[6:0] == 7'h38
            && HUE_ALIGN_SECTORS[2:0] == 3'h4 && HUE_ALIGN_PRESENT)
        else $error("first preset sector values wrong");

    a_preset_b_load: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_PRESET_B
        |=> HUE_ADJ_SEL == 4'h2 && LIGHT_MAP_SEL == 4'h2 && HUE_KEEP_SECTORS == 42'h0
            && !CHROMA_ADJUST_PRESENT)
        else $error("second preset not loaded");

    a_explicit_mode: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_EXPLICIT
        |=> GM_METHOD == GM_EXPLICIT && !PRESET_VALID)
        else $error("explicit selector misdecoded");

    a_path_route: assert property (
        pic_start && MD_VALID |=> PATH_TABLE_EN == $past(MD_CARRIAGE)
            && PATH_PARAM_EN != PATH_TABLE_EN)
        else $error("carriage routed to wrong path");

    a_sdr_peak: assert property (
        !OUT_HDR |-> OUT_PEAK_LUM == 14'h0064 && !RECOMPUTE_EN)
        else $error("SDR output not at fixed peak");

    a_mode_stable: assert property (
        !pic_start |=> $stable(GM_METHOD) && $stable(OUT_HDR))
        else $error("picture metadata changed mid picture");

    a_peak_floor: assert property (
        wr_peak && PWDATA[13:0] < 14'h0064 |=> peak_reg == 14'h0064)
        else $error("peak below SDR level accepted");

    a_hdr_follow: assert property (
        pic_start |=> OUT_HDR == $past(ctrl_adapt_reg) && OUT_SOF)
        else $error("output range does not follow adaptation");

    a_good_sel: assert property (
        MD_VALID && MD_GAMUT_SEL[7:6] == 2'b01 && !status_reg[0]
        |=> !status_reg[0])
        else $error("permitted code flagged");

    a_impl_mode: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == 8'h00
        |=> GM_METHOD == GM_IMPL && !PRESET_VALID)
        else $error("code zero misdecoded");

    a_unspec_mode: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL[7:6] == 2'b01
        |=> GM_METHOD == GM_UNSPEC && !PRESET_VALID)
        else $error("unspecified code misdecoded");

    a_preset_a_sat: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == 8'h04
        |=> SAT_MAP_SEL == 4'h1 && SAT_RATIO_1SEG == 7'h38 && LIGHT_MAP_SEL == 4'h2)
        else $error("first preset fields wrong");

    a_preset_a_align: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == 8'h04
        |=> HUE_ALIGN_SECTORS == 18'h0d88c)
        else $error("first preset align wrong");

    a_preset_b_align: assert property (
        pic_start && MD_VALID && MD_GAMUT_SEL == 8'h05
        |=> HUE_ALIGN_SECTORS == 18'h0d88c && HUE_ALIGN_PRESENT && CROP_SEL == 4'h0)
        else $error("second preset align wrong");

    a_sample_pass: assert property (
        VID_VALID
        |=> OUT_VALID && OUT_SAMPLE == $past(VID_SAMPLE))
        else $error("sample not passed on");

    a_flag_clear: assert property (
        wr_status && PWDATA[0] && !bad_sel
        |=> !status_reg[0])
        else $error("flag not cleared");

    a_pend_apply: assert property (
        pic_start && !MD_VALID
        |=> GM_METHOD == $past(pend_mode_reg))
        else $error("stored metadata not applied");

    a_hdr_peak: assert property (
        OUT_HDR
        |-> OUT_PEAK_LUM >= 14'h0064)
        else $error("adapted peak below SDR");

    c_preset_a: cover property (pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_PRESET_A);
    c_preset_b: cover property (pic_start && MD_VALID && MD_GAMUT_SEL == GPM_CODE_PRESET_B);
    c_bad_irq: cover property (bad_sel ##1 IRQ);
    c_hdr_pic: cover property (pic_start && ctrl_adapt_reg);
    c_sep_md: cover property (MD_VALID && !pic_start ##2 pic_start);

endmodule : gpm_decoder
`default_nettype wire

// [tb/gpm_src_model.sv]
// Partner model: video decoder handing parsed metadata and picture samples to the block
`timescale 1ns/1ps
`default_nettype none
module gpm_src_model (
    input wire logic clk,
    output logic md_valid,
    output logic [7:0] md_gamut_sel,
    output logic md_carriage,
    output logic vid_valid,
    output logic vid_sof,
    output logic [29:0] vid_sample
);
    logic [9:0] cnt = 10'h3fc;

    initial begin
        md_valid = 1'b0;
        md_gamut_sel = 8'h00;
        md_carriage = 1'b0;
        vid_valid = 1'b0;
        vid_sof = 1'b0;
        vid_sample = 30'h0;
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // One picture of four samples; sep sends the metadata alone two cycles before the start
    task automatic pic(input logic [7:0] sel, input logic car, input logic sep);
        if (sep) begin
            @(posedge clk);
            md_valid <= 1'b1;
            md_gamut_sel <= sel;
            md_carriage <= car;
            @(posedge clk);
            md_valid <= 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            md_valid <= (i == 0) && !sep;
            // Idle metadata lines show the inverse so a stale capture is caught
            md_gamut_sel <= (i == 0 && !sep) ? sel : ~sel;
            md_carriage <= (i == 0 && !sep) ? car : ~car;
            vid_valid <= 1'b1;
            vid_sof <= (i == 0);
            vid_sample <= {cnt, ~cnt, cnt ^ 10'h2aa};
            cnt <= cnt + 10'h1;
        end
        @(posedge clk);
        md_valid <= 1'b0;
        vid_valid <= 1'b0;
        vid_sof <= 1'b0;
        vid_sample <= ~vid_sample;
        @(posedge clk);
    endtask : pic
endmodule : gpm_src_model
`default_nettype wire

// [tb/gpm_decoder_tb.sv]
// Testbench: self-checking bench of the gamut preset metadata decoder
`timescale 1ns/1ps
`default_nettype none
module gpm_decoder_tb;
    import gpm_pkg::*;
    localparam logic [6:0] KO = 7'h38;
    logic SYS_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, MD_VALID, MD_CARRIAGE, VID_VALID, VID_SOF, OUT_VALID, OUT_SOF;
    logic [7:0] MD_GAMUT_SEL;
    logic [29:0] VID_SAMPLE, OUT_SAMPLE;
    logic OUT_HDR, RECOMPUTE_EN, PATH_PARAM_EN, PATH_TABLE_EN, PRESET_VALID, IRQ;
    logic [13:0] OUT_PEAK_LUM;
    gpm_gm_type GM_METHOD;
    logic [3:0] SAT_MAP_SEL, LIGHT_MAP_SEL, CROP_SEL, HUE_ADJ_SEL;
    logic [6:0] SAT_RATIO_1SEG, SAT_RATIO_2SEG_WIDE, SAT_RATIO_2SEG_STD, HUE_KEEP_OVERALL;
    logic [41:0] HUE_KEEP_SECTORS;
    logic HUE_ALIGN_PRESENT, CHROMA_ADJUST_PRESENT;
    logic [17:0] HUE_ALIGN_SECTORS;
    int err_count = 0;
    int num_checks = 0;
    logic mon_on = 1'b0;
    logic [31:0] vq;
    logic [31:0] r;
    logic e, pa, pb, bad;
    gpm_gm_type m;
    logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h3f,
                                8'h40, 8'h7f, 8'h80, 8'hff};

    always #20 SYS_CLK = ~SYS_CLK;

    gpm_decoder #(.KEEP_OVERALL(KO)) DUT (.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MD_VALID, .MD_GAMUT_SEL, .MD_CARRIAGE, .VID_VALID,
        .VID_SOF, .VID_SAMPLE, .OUT_VALID, .OUT_SOF, .OUT_SAMPLE, .OUT_HDR, .OUT_PEAK_LUM,
        .RECOMPUTE_EN, .PATH_PARAM_EN, .PATH_TABLE_EN, .GM_METHOD, .PRESET_VALID, .SAT_MAP_SEL,
        .SAT_RATIO_1SEG, .SAT_RATIO_2SEG_WIDE, .SAT_RATIO_2SEG_STD, .LIGHT_MAP_SEL, .CROP_SEL,
        .HUE_ADJ_SEL, .HUE_KEEP_SECTORS, .HUE_KEEP_OVERALL, .HUE_ALIGN_PRESENT,
        .HUE_ALIGN_SECTORS, .CHROMA_ADJUST_PRESENT, .IRQ);

    gpm_src_model src (.clk(SYS_CLK), .md_valid(MD_VALID), .md_gamut_sel(MD_GAMUT_SEL),
        .md_carriage(MD_CARRIAGE), .vid_valid(VID_VALID), .vid_sof(VID_SOF),
        .vid_sample(VID_SAMPLE));

    //////////////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t no bus answer", $time);
            final_report();
        end else begin
            r = PRDATA;
            e = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk(e, 1'b0);
    endtask : rdc

    function automatic gpm_gm_type exp_method(input logic [7:0] c);
        if (c == 8'h01) return GM_EXPLICIT;
        if (c == 8'h04) return GM_PRESET_A;
        if (c == 8'h05) return GM_PRESET_B;
        if (c >= 8'h40 && c <= 8'h7f) return GM_UNSPEC;
        return GM_IMPL;
    endfunction : exp_method

    // Output samples are the input samples one cycle late
    always @(posedge SYS_CLK) vq <= {VID_VALID, VID_SOF, VID_SAMPLE};
    always @(negedge SYS_CLK) if (mon_on) chk({OUT_VALID, OUT_SOF, OUT_SAMPLE}, vq);

    //////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        @(negedge SYS_CLK);
        mon_on = 1'b1;
        chk(OUT_PEAK_LUM, 14'd100);
        chk({GM_METHOD, PATH_PARAM_EN, PATH_TABLE_EN, OUT_HDR, IRQ}, {GM_IMPL, 4'b1000});
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'd100);
        rdc(8'h08, 32'h0);
        rdc(8'h0c, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        // Every selector class, alternating carriage mode
        for (int i = 0; i < 12; i++) begin
            src.pic(codes[i], i[0], 1'b0);
            m = exp_method(codes[i]);
            pa = (m == GM_PRESET_A);
            pb = (m == GM_PRESET_B);
            bad = !(codes[i] <= 8'h01 || pa || pb || m == GM_UNSPEC);
            chk(GM_METHOD, m);
            chk({PATH_TABLE_EN, PATH_PARAM_EN}, {i[0], !i[0]});
            chk(PRESET_VALID, pa | pb);
            chk({SAT_MAP_SEL, SAT_RATIO_1SEG}, (pa | pb) ? {4'h1, 7'h38} : 11'h0);
            chk({SAT_RATIO_2SEG_WIDE, SAT_RATIO_2SEG_STD}, (pa | pb) ? 14'h0e9d : 14'h0);
            chk({LIGHT_MAP_SEL, CROP_SEL}, (pa | pb) ? 8'h20 : 8'h00);
            chk(HUE_ADJ_SEL, pa ? 4'h3 : (pb ? 4'h2 : 4'h0));
            if (!pb) chk(HUE_KEEP_SECTORS, pa ? 42'h1c3070e1c38 : 42'h0);
            if (pb) chk(HUE_KEEP_OVERALL, KO);
            chk(HUE_ALIGN_PRESENT, pa | pb);
            chk(HUE_ALIGN_SECTORS, (pa | pb) ? {3'h1, 3'h5, 3'h4, 3'h2, 3'h1, 3'h4} : 18'h0);
            chk(CHROMA_ADJUST_PRESENT, 1'b0);
            rdc(8'h08, {30'h0, 1'b1, bad});
            apb(1'b1, 8'h08, 32'h7);
        end
        // Target peak: below SDR is clamped, far above any mastering peak is kept
        apb(1'b1, 8'h04, 32'd50);
        rdc(8'h04, 32'd100);
        rdc(8'h08, 32'h4);
        apb(1'b1, 8'h04, 32'h3fff);
        rdc(8'h04, 32'h3fff);
        apb(1'b1, 8'h00, 32'h1);
        @(negedge SYS_CLK);
        chk(OUT_HDR, 1'b0);
        src.pic(8'h05, 1'b1, 1'b1);
        chk({OUT_HDR, RECOMPUTE_EN, OUT_PEAK_LUM}, {2'b11, 14'h3fff});
        chk({GM_METHOD, PATH_TABLE_EN}, {GM_PRESET_B, 1'b1});
        rdc(8'h10, {2'h0, 14'h3fff, 10'h0, GM_PRESET_B, 3'b011});
        apb(1'b1, 8'h00, 32'h0);
        src.pic(8'h04, 1'b0, 1'b0);
        chk({OUT_HDR, RECOMPUTE_EN, OUT_PEAK_LUM}, {2'b00, 14'd100});
        chk({GM_METHOD, SAT_RATIO_1SEG}, {GM_PRESET_A, 7'h38});
        // Interrupt: raised, masked, cleared
        apb(1'b1, 8'h08, 32'h7);
        src.pic(8'h02, 1'b0, 1'b0);
        @(negedge SYS_CLK);
        chk(IRQ, 1'b0);
        apb(1'b1, 8'h0c, 32'h1);
        rdc(8'h0c, 32'h1);
        @(negedge SYS_CLK);
        chk(IRQ, 1'b1);
        apb(1'b1, 8'h08, 32'h1);
        @(negedge SYS_CLK);
        chk(IRQ, 1'b0);
        chk(GM_METHOD, GM_IMPL);
        final_report();
    end
endmodule : gpm_decoder_tb
`default_nettype wire
